// File: verilog/asp_port.sv
// slave serial port of a dual-axis acceleration sensor
// Contract
// - with chip select high the port ignores clock and data entirely
// - data is exchanged only while chip select is held low
// - samples and status are returned on the serial output
// - data registers refresh at 800 kHz regardless of transfers
// - two measurement paths, x and y/z, both readable
// - each transfer swaps one 16-bit word each way
// - slave only, mode 0: change on falling, sample on rising
// - output is released when not selected, driven only when selected
`timescale 1ns/10ps
module asp_port
  import asp_pkg::*;
#(
  parameter int STARTUP = STARTUP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic factory_test_pin,
  input wire logic [SAMPLE_BITS-1:0] accel_x,
  input wire logic [SAMPLE_BITS-1:0] accel_yz,
  input wire logic hw_error,
  output logic miso_out,
  output logic miso_oe,
  output logic ctrl_tc,
  output logic ctrl_st,
  output logic link_ready
);
  asp_pins_t pins_s;
  asp_state_t s;
  asp_state_t next_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic [WORD_BITS-1:0] word_now;
  logic [WORD_BITS-1:0] cmd_word;
  logic word_done;
  asp_pins_t pins_raw;

  // mosi passes the same two stages as sck, so it is sampled in step with the synced edge
  assign pins_raw = '{sck: sck, chip_select_n: chip_select_n, mosi: mosi};

  asp_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  function automatic logic [WORD_BITS-1:0] out_word(input logic sel,
      input logic err, input logic [SAMPLE_BITS-1:0] x, input logic [SAMPLE_BITS-1:0] yz);
    out_word = sel ? {1'b1, err, yz} : {1'b0, err, x};
  endfunction : out_word

  assign sck_rise = pins_s.sck & ~s.sck_prev;
  assign sck_fall = ~pins_s.sck & s.sck_prev;
  assign cs_fall = ~pins_s.chip_select_n & s.cs_prev;
  assign word_now = out_word(s.sel, hw_error, s.data_x, s.data_yz);
  assign cmd_word = {s.shift[WORD_BITS-2:0], pins_s.mosi};
  // last rising edge of a full word: commands act only here, so a cut frame does nothing
  assign word_done = s.oe && sck_rise && !pins_s.chip_select_n &&
      s.bit_cnt == 5'(WORD_BITS - 1);

  always_comb begin
    next_s = s;
    next_s.sck_prev = pins_s.sck;
    next_s.cs_prev = pins_s.chip_select_n;
    next_s.refresh_pulse = 1'b0;
    if (!s.ready) begin
      next_s.startup_cnt = s.startup_cnt + 16'h0001;
      if (s.startup_cnt == 16'(STARTUP - 1)) begin
        next_s.ready = 1'b1;
      end
    end
    // refresh runs free so the host never stalls the sample stream
    if (s.refresh_cnt == 5'(REFRESH_CYCLES - 1)) begin
      next_s.refresh_cnt = 5'h00;
      next_s.refresh_pulse = 1'b1;
      next_s.data_x = accel_x;
      next_s.data_yz = accel_yz;
    end else begin
      next_s.refresh_cnt = s.refresh_cnt + 5'h01;
    end
    if (!s.ready || pins_s.chip_select_n) begin
      next_s.oe = 1'b0;
      next_s.miso = 1'b0;
      next_s.bit_cnt = 5'h00;
    end else if (cs_fall) begin
      // snapshot now so a refresh in mid-frame cannot tear the outgoing word
      next_s.shift = word_now;
      next_s.oe = 1'b1;
      next_s.miso = word_now[WORD_BITS-1];
      next_s.bit_cnt = 5'h00;
    end else if (s.oe) begin
      if (sck_rise && s.bit_cnt < 5'(WORD_BITS)) begin
        next_s.shift = cmd_word;
        next_s.bit_cnt = s.bit_cnt + 5'h01;
        if (s.bit_cnt == 5'(WORD_BITS - 1)) begin
          if (cmd_word[CMD_WRITE_BIT]) begin
            next_s.tc = cmd_word[CTRL_TC_BIT];
            next_s.st = cmd_word[CTRL_ST_BIT];
          end else begin
            next_s.sel = cmd_word[CMD_SEL_BIT];
          end
        end
      end
      // bits past the sixteenth are ignored; the pin holds the last value
      if (sck_fall && s.bit_cnt != 5'h00 && s.bit_cnt < 5'(WORD_BITS)) begin
        next_s.miso = s.shift[WORD_BITS-1];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{startup_cnt: 16'h0000, ready: 1'b0, refresh_cnt: 5'h00, refresh_pulse: 1'b0,
             data_x: '0, data_yz: '0, shift: '0, bit_cnt: 5'h00, sck_prev: 1'b0,
             cs_prev: 1'b1, sel: SEL_RESET, tc: CTRL_TC_RESET, st: CTRL_ST_RESET,
             miso: 1'b0, oe: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign miso_out = s.miso;
  assign miso_oe = s.oe;
  assign ctrl_tc = s.tc;
  assign ctrl_st = s.st;
  assign link_ready = s.ready;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // the checks watch the synced pins, which are what the port itself acts on
  idle_release_a: assert property (pins_s.chip_select_n |=> !miso_oe)
    else $error("output driven while deselected");
  idle_count_a: assert property (pins_s.chip_select_n |=> s.bit_cnt == 5'h00)
    else $error("bit count kept while deselected");
  late_select_a: assert property (!s.oe && !cs_fall |=> !miso_oe)
    else $error("output driven without a select edge");
  early_silence_a: assert property (!link_ready |-> !miso_oe)
    else $error("driven before startup");
  miso_quiet_a: assert property (!miso_oe |-> !miso_out)
    else $error("miso not parked low while released");

  // a select edge loads the snapshot and drives its msb at once
  select_drive_a: assert property (cs_fall && s.ready |=> miso_oe)
    else $error("output not driven after select");
  first_bit_a: assert property (cs_fall && s.ready |=> miso_out == $past(word_now[15]))
    else $error("first bit is not the word msb");
  status_bits_a: assert property (cs_fall && s.ready |=>
      s.shift[15] == $past(s.sel) && s.shift[14] == $past(hw_error))
    else $error("path or error bit wrong in snapshot");
  snapshot_a: assert property (cs_fall && s.ready |=>
      s.shift[13:0] == ($past(s.sel) ? $past(s.data_yz) : $past(s.data_x)))
    else $error("snapshot does not match selected path");

  // refresh period and sample loads
  refresh_rate_a: assert property (s.refresh_pulse |-> ##25 s.refresh_pulse)
    else $error("refresh period wrong");
  refresh_gap_a: assert property (s.refresh_pulse |=>
      (!s.refresh_pulse)[*8] ##1 (!s.refresh_pulse)[*8] ##1
      (!s.refresh_pulse)[*8])
    else $error("refresh too frequent");
  refresh_load_a: assert property (s.refresh_pulse |->
      s.data_x == $past(accel_x) && s.data_yz == $past(accel_yz))
    else $error("sample paths not loaded on refresh");
  data_hold_a: assert property (s.refresh_cnt != 5'(REFRESH_CYCLES - 1) |=>
      $stable(s.data_x) && $stable(s.data_yz))
    else $error("sample changed between refreshes");

  // startup wait
  startup_time_a: assert property ($rose(link_ready) |->
      $past(s.startup_cnt) == 16'(STARTUP - 1))
    else $error("startup length wrong");
  startup_count_a: assert property (!link_ready |=>
      s.startup_cnt == $past(s.startup_cnt) + 16'h0001)
    else $error("startup counter stalled");
  ready_hold_a: assert property (link_ready |=> link_ready)
    else $error("ready dropped without reset");

  // shifting: one word each way, later edges ignored
  bit_count_a: assert property (s.oe && sck_rise && !pins_s.chip_select_n &&
      s.bit_cnt < 5'(WORD_BITS) |=> s.bit_cnt == $past(s.bit_cnt) + 5'h01)
    else $error("bit count did not advance");
  bit_limit_a: assert property (s.bit_cnt <= 5'(WORD_BITS))
    else $error("more than one word shifted");
  shift_in_a: assert property (s.oe && sck_rise && !pins_s.chip_select_n &&
      s.bit_cnt < 5'(WORD_BITS) |=> s.shift == {$past(s.shift[14:0]), $past(pins_s.mosi)})
    else $error("serial input not shifted in");
  shift_out_a: assert property (s.oe && !pins_s.chip_select_n && sck_fall &&
      s.bit_cnt != 5'h00 && s.bit_cnt < 5'(WORD_BITS) |=> miso_out == $past(s.shift[15]))
    else $error("miso not updated on falling edge");
  miso_steady_a: assert property (s.oe && !pins_s.chip_select_n && !sck_fall |=>
      $stable(miso_out))
    else $error("miso changed away from a falling edge");

  // commands act only on the sixteenth rising edge
  ctrl_load_a: assert property (word_done && cmd_word[CMD_WRITE_BIT] |=>
      ctrl_tc == $past(cmd_word[CTRL_TC_BIT]) && ctrl_st == $past(cmd_word[CTRL_ST_BIT]))
    else $error("control write not applied");
  ctrl_hold_a: assert property (!word_done |=> $stable(ctrl_tc) && $stable(ctrl_st))
    else $error("control bits changed outside a full word");
  path_select_a: assert property (word_done && !cmd_word[CMD_WRITE_BIT] |=>
      s.sel == $past(cmd_word[CMD_SEL_BIT]))
    else $error("path select not taken");
  sel_hold_a: assert property (!(word_done && !cmd_word[CMD_WRITE_BIT]) |=> $stable(s.sel))
    else $error("path select changed without a read request");

  full_word_c: cover property (s.oe && s.bit_cnt == 5'(WORD_BITS));
  yz_read_c: cover property (cs_fall && s.ready && s.sel);
  ctrl_write_c: cover property ($rose(ctrl_tc) || $rose(ctrl_st));
  cut_frame_c: cover property (s.oe && pins_s.chip_select_n && s.bit_cnt == 5'h08);
  early_select_c: cover property (cs_fall && !s.ready);
endmodule : asp_port

// File: inc/asp_pkg.sv
// shared constants and types for the accelerometer serial port
package asp_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int REFRESH_HZ = 800_000;
  localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;
  localparam int STARTUP_US = 1000;
  localparam int STARTUP_CYCLES = (CLK_HZ / 1_000_000) * STARTUP_US;
  localparam int WORD_BITS = 16;
  localparam int SAMPLE_BITS = 14;
  localparam int CMD_WRITE_BIT = 15;
  localparam int CTRL_TC_BIT = 0;
  localparam int CTRL_ST_BIT = 1;
  localparam int CMD_SEL_BIT = 0;
  localparam int WORD_CHAN_BIT = 15;
  localparam int WORD_ERR_BIT = 14;
  localparam logic CTRL_TC_RESET = 1'b0;
  localparam logic CTRL_ST_RESET = 1'b0;
  localparam logic SEL_RESET = 1'b0;

  typedef struct packed {
    logic sck;
    logic chip_select_n;
    logic mosi;
  } asp_pins_t;

  typedef struct packed {
    asp_pins_t stage1;
    asp_pins_t stage2;
  } asp_sync_state_t;

  typedef struct packed {
    logic [15:0] startup_cnt;
    logic ready;
    logic [4:0] refresh_cnt;
    logic refresh_pulse;
    logic [SAMPLE_BITS-1:0] data_x;
    logic [SAMPLE_BITS-1:0] data_yz;
    logic [WORD_BITS-1:0] shift;
    logic [4:0] bit_cnt;
    logic sck_prev;
    logic cs_prev;
    logic sel;
    logic tc;
    logic st;
    logic miso;
    logic oe;
  } asp_state_t;
endpackage : asp_pkg

// File: verilog/asp_sync.sv
// two-stage synchroniser for the serial port pins
`timescale 1ns/10ps
module asp_sync
  import asp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire asp_pins_t pins_in,
  output asp_pins_t pins_out
);
  asp_sync_state_t s;
  asp_sync_state_t next_s;

  // chip select idles high so a reset never looks like a selection
  always_comb begin
    next_s = s;
    next_s.stage1 = pins_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{stage1: '{sck: 1'b0, chip_select_n: 1'b1, mosi: 1'b0},
             stage2: '{sck: 1'b0, chip_select_n: 1'b1, mosi: 1'b0}};
    end else begin
      s <= next_s;
    end
  end

  assign pins_out = s.stage2;
endmodule : asp_sync

// File: tb/asp_host.sv
// host side model of the serial link, mode 0, link clock still between frames
`timescale 1ns/10ps
module asp_host (
  output logic sck,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  // sel low keeps chip select high; n below 16 cuts the frame short
  // callers start just after a clock edge; every step is whole clocks, so pins stay off the edge
  task automatic xfer(input logic [15:0] tx, input int n, input logic sel,
      output logic [15:0] rx);
    chip_select_n = ~sel;
    #200;
    for (int i = 15; i > 15 - n; i--) begin
      mosi = tx[i];
      #200 sck = 1'b1;
      rx[i] = miso_oe ? miso_out : 1'bx;
      #200 sck = 1'b0;
    end
    // released data line falls to its pull-down level
    mosi = 1'b0;
    #200 chip_select_n = 1'b1;
    #400;
  endtask : xfer
endmodule : asp_host

// File: tb/testbench.sv
// self-checking bench for the accelerometer serial port
`timescale 1ns/10ps
module testbench;
  import asp_pkg::*;
  logic clk, rst_n, hw_error, sck, chip_select_n, mosi;
  logic miso_out, miso_oe, ctrl_tc, ctrl_st, link_ready;
  logic [SAMPLE_BITS-1:0] accel_x, accel_yz;
  logic [15:0] rx;
  int error_cnt = 0;
  int compares = 0;
  asp_port #(.STARTUP(50)) DUT (.clk(clk), .rst_n(rst_n), .sck(sck),
    .chip_select_n(chip_select_n), .mosi(mosi), .factory_test_pin(1'b0),
    .accel_x(accel_x), .accel_yz(accel_yz), .hw_error(hw_error),
    .miso_out(miso_out), .miso_oe(miso_oe), .ctrl_tc(ctrl_tc),
    .ctrl_st(ctrl_st), .link_ready(link_ready));
  asp_host host (.sck(sck), .chip_select_n(chip_select_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic xw(input logic [15:0] w, input int n, input logic [1:0] exp);
    host.xfer(w, n, 1'b1, rx);
    chk({14'h0, ctrl_st, ctrl_tc}, {14'h0, exp});
  endtask : xw
  task automatic t_early();
    chk({15'h0, link_ready}, 16'h0);
    xw(16'h8003, 16, 2'b00);
    chk({15'h0, link_ready}, 16'h1);
  endtask : t_early
  task automatic t_unsel();
    host.xfer(16'h8003, 16, 1'b0, rx);
    chk({13'h0, ctrl_st, ctrl_tc, miso_oe}, 16'h0);
    chk(rx, 16'hxxxx);
  endtask : t_unsel
  task automatic t_read();
    @(posedge clk);
    #5 accel_x = 14'h1abc;
    accel_yz = 14'h0567;
    hw_error = 1'b1;
    repeat (60) @(posedge clk);
    #5 fork
      host.xfer(16'h0001, 16, 1'b1, rx);
      #1000 accel_x = 14'h0123;
    join
    chk(rx, 16'h5abc);
    host.xfer(16'h0000, 16, 1'b1, rx);
    chk(rx, 16'hc567);
    host.xfer(16'h0000, 16, 1'b1, rx);
    chk(rx, 16'h4123);
  endtask : t_read
  task automatic t_ctrl();
    xw(16'h8003, 16, 2'b11);
    // a cut frame must not disturb the control bits
    xw(16'h8000, 8, 2'b11);
    xw(16'h8001, 16, 2'b01);
    xw(16'h8002, 16, 2'b10);
    xw(16'h8000, 16, 2'b00);
  endtask : t_ctrl
  // a reset in mid-run clears control and path select and restarts the startup wait
  task automatic t_reset();
    host.xfer(16'h0001, 16, 1'b1, rx);
    xw(16'h8003, 16, 2'b11);
    rst_n = 1'b0;
    hw_error = 1'b0;
    repeat (4) @(posedge clk);
    #5 chk({13'h0, ctrl_st, ctrl_tc, miso_oe}, 16'h0);
    chk({15'h0, link_ready}, 16'h0);
    rst_n = 1'b1;
    repeat (60) @(posedge clk);
    #5 chk({15'h0, link_ready}, 16'h1);
    host.xfer(16'h0000, 16, 1'b1, rx);
    chk(rx, 16'h0123);
  endtask : t_reset
  initial begin
    rst_n = 1'b0;
    accel_x = 14'h0;
    accel_yz = 14'h0;
    hw_error = 1'b0;
    repeat (16) @(posedge clk);
    #5 rst_n = 1'b1;
    t_early();
    t_unsel();
    t_read();
    t_ctrl();
    t_reset();
    close_out();
  end
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule : testbench
